// >>> core/svid_seq_pkg.sv
// Constants, types and timing for the serial VID reference sequencer.
package svid_seq_pkg;

  typedef logic [6:0] vid_t;

  // Clock period and reference step timing, times in nanoseconds.
  localparam int CLK_NS = 50;
  localparam int SS_STEP_NS = 6250; // One 12.5 mV code at 2 mV/us.
  localparam int SLEW_STEP_NS = 1667; // One code at 7.5 mV/us.
  localparam int MAX_STEP_NS = 1250; // One code at 10 mV/us.
  localparam int SS_CYC = (SS_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLEW_CYC = (SLEW_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_RATE_CYC = (MAX_STEP_NS + CLK_NS - 1) / CLK_NS;

  // Code layout: 0 is 1.55 V, each code 12.5 mV lower, top four are off.
  localparam vid_t VID_FLOOR = 7'h7b;
  localparam vid_t VID_OFF_FIRST = 7'h7c;
  localparam vid_t VID_RST = 7'h00;

  // Start-up codes indexed by {clock line, data line}.
  localparam vid_t START_TBL [4] = '{7'h24, 7'h2c, 7'h34, 7'h3c};
  localparam vid_t FIXED_TBL [4] = '{7'h0c, 7'h1c, 7'h2c, 7'h3c};

  // Address byte as received: tag, reserved, plane selects, write bit.
  localparam logic [2:0] ADDR_TAG = 3'h6;
  localparam int ADR_TAG_HI = 7;
  localparam int ADR_TAG_LO = 5;
  localparam int ADR_PL_HI = 3;
  localparam int ADR_PL_LO = 1;
  localparam int ADR_RW = 0;
  localparam logic RW_WRITE = 1'h0;
  localparam int DAT_PSI = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Plane index: 2 second core, 1 first core, 0 northbridge.
  localparam int NPLANE = 3;

  typedef struct packed {
    logic [2:0] planes;
    logic power_saving_request_low;
    vid_t vid;
  } svi_cmd_t;

  typedef enum {ST_OFF, ST_SOFT, ST_RUN} ctl_state_t;
  typedef enum {L_IDLE, L_ADDR, L_AACK, L_DATA, L_DACK, L_STOP} link_state_t;

endpackage : svid_seq_pkg

// >>> core/svid_seq.sv
// Serial VID reference sequencer: start-up latch, soft-start, command link and slewing.
`timescale 1ns/10ps

// Overview of operation
// - Before enable, clock/data straps select start-up code 1.1, 1.0, 0.9 or 0.8 V.
// - Enable rising captures the decoded start-up code into a holding register.
// - After capture, all plane references ramp to target at about 2 mV/us.
// - Power-good rises once soft-start ends and all planes are in regulation.
// - Enable loss tri-states the output drivers and drops power-good.
// - Supply reset shuts all planes, drops power-good, discards the start-up code.
// - On restart the straps are sampled afresh and soft-start repeats.
// - Fixed mode straps select 1.4, 1.2, 1.0 or 0.8 V, treated as static.
// - Fixed mode soft-starts at 2 mV/us and then raises power-good.
// - While power-ok is high, the link is watched for set-VID commands.
// - A command selects one or more planes and one target code shared by all of them.
// - Turning a core plane off leaves power-good asserted.
// - Power-ok low steps all planes back to the held code, link ignored.
// - Power-ok high again waits for a command before moving any plane.
// - Enable loss clears the held start-up code.
// - Upward commanded moves slew at about 7.5 mV/us.
// - Downward moves slew at about 7.5 mV/us with continuous conduction forced.
// - Run-state reference slew never exceeds 10 mV/us in either direction.
// - Power-good is not changed by on-the-fly transitions.
// - A valid instruction is acknowledged on the link before it is acted on.
// - Seven-bit code, 1.55 V at zero, 12.5 mV steps, top four off, bit 7 power-saving.
// - Address tag 110b; bits 2, 1, 0 select second core, first core, northbridge.
// - Address and data are acknowledged; the move starts only after stop.
module svid_seq
  import svid_seq_pkg::*;
#(
  parameter int SS_CYCLES = SS_CYC,
  parameter int SLEW_CYCLES = SLEW_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_enable,
  input wire logic i_fixed_strap_voltage_mode,
  input wire logic i_cpu_power_ok_input,
  input wire logic i_in_regulation,
  input wire logic i_vid_serial_clock_line,
  input wire logic i_vid_serial_data_line,
  output logic o_vid_serial_data_line_out,
  output logic o_vid_serial_data_line_oe,
  output logic o_drivers_enable,
  output logic o_outputs_in_regulation_flag,
  output logic o_continuous_conduction_mode,
  output logic o_power_saving_request_low,
  output vid_t [NPLANE-1:0] o_plane_ref
);

  // The step timers are eight bits wide, and the slew may never beat 10 mV/us.
  if (SS_CYCLES < 1 || SS_CYCLES > 255 || SLEW_CYCLES < MAX_RATE_CYC || SLEW_CYCLES > 255) begin : g_chk
    $error("svid_seq: step interval parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main clock domain: pin synchronisers.

  logic [1:0] en_q, pok_q, mode_q, reg_q, clk_q, dat_q, tgl_q;
  logic en_d, tgl_d;
  logic en_s, pok_s, mode_s, reg_s;

  // Every pin but the supply reset passes two flops before logic reads it.
  always_ff @(posedge i_mclk) begin
    en_q <= {en_q[0], i_enable};
    pok_q <= {pok_q[0], i_cpu_power_ok_input};
    mode_q <= {mode_q[0], i_fixed_strap_voltage_mode};
    reg_q <= {reg_q[0], i_in_regulation};
    clk_q <= {clk_q[0], i_vid_serial_clock_line};
    dat_q <= {dat_q[0], i_vid_serial_data_line};
    en_d <= en_q[1];
  end

  assign en_s = en_q[1];
  assign pok_s = pok_q[1];
  assign mode_s = mode_q[1];
  assign reg_s = reg_q[1];

  // Strap decode; the table follows the mode strap.
  function automatic vid_t strap_code(input logic fixed, input logic c, input logic d);
    strap_code = fixed ? FIXED_TBL[{c, d}] : START_TBL[{c, d}];
  endfunction : strap_code

  //////////////////////////////////////////////////////////////////////////////
  // Main clock domain: sequencing state.

  ctl_state_t state_r;
  vid_t hold_r;
  vid_t [NPLANE-1:0] tgt_r;
  vid_t [NPLANE-1:0] ref_r;
  logic outputs_in_regulation_flag_r, psi_r;
  logic cmd_go;
  logic cmd_pend_r;
  logic link_ok;
  svi_cmd_t cmd_r;
  svi_cmd_t lcmd_r;
  logic ltgl_r;
  logic all_done;

  // Fixed mode keeps the link silent even if power-ok is driven.
  assign link_ok = pok_s && !mode_s;
  assign cmd_go = cmd_pend_r && link_ok && (state_r == ST_RUN);
  assign all_done = (ref_r == tgt_r);

  // The command word is held still in the link domain long before its toggle lands here.
  // The go pulse trails the toggle by one cycle, so targets read the freshly loaded word.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tgl_q <= 2'h0;
      tgl_d <= 1'h0;
      cmd_r <= '0;
      cmd_pend_r <= 1'h0;
    end else begin
      tgl_q <= {tgl_q[0], ltgl_r};
      tgl_d <= tgl_q[1];
      cmd_pend_r <= (tgl_q[1] != tgl_d);
      if (tgl_q[1] != tgl_d) begin
        cmd_r <= lcmd_r;
      end
    end
  end

  // Supply reset and enable loss both drop to off and forget the held code.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_r <= ST_OFF;
      hold_r <= VID_RST;
    end else if (!en_s) begin
      state_r <= ST_OFF;
      hold_r <= VID_RST;
    end else begin
      case (state_r)
        ST_OFF: begin
          // Off with enable high is a start, also when enable was already high at supply reset.
          hold_r <= strap_code(mode_s, clk_q[1], dat_q[1]);
          state_r <= ST_SOFT;
        end
        ST_SOFT: begin
          if (all_done) begin
            state_r <= ST_RUN;
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Targets: held code at start and when power-ok is low, commanded codes otherwise.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !en_s) begin
      tgt_r <= {NPLANE{VID_FLOOR}};
      psi_r <= 1'h1;
    end else if (state_r == ST_OFF) begin
      tgt_r <= {NPLANE{strap_code(mode_s, clk_q[1], dat_q[1])}};
    end else if (state_r == ST_RUN && !link_ok) begin
      tgt_r <= {NPLANE{hold_r}};
      psi_r <= 1'h1;
    end else if (cmd_go) begin
      for (int p = 0; p < NPLANE; p++) begin
        if (cmd_r.planes[p]) begin
          tgt_r[p] <= cmd_r.vid;
        end
      end
      psi_r <= cmd_r.power_saving_request_low;
    end
  end

  // Each plane steps one code per interval toward its target.
  for (genvar g = 0; g < NPLANE; g++) begin : g_plane
    logic [7:0] tmr_r;
    logic [7:0] lim;
    assign lim = (state_r == ST_SOFT) ? 8'(SS_CYCLES - 1) : 8'(SLEW_CYCLES - 1);
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n || !en_s || state_r == ST_OFF) begin
        tmr_r <= 8'h00;
        ref_r[g] <= VID_FLOOR;
      end else if (ref_r[g] == tgt_r[g]) begin
        tmr_r <= 8'h00;
      end else if (tmr_r >= lim) begin
        tmr_r <= 8'h00;
        ref_r[g] <= (tgt_r[g] < ref_r[g]) ? ref_r[g] - 7'h01 : ref_r[g] + 7'h01;
      end else begin
        tmr_r <= tmr_r + 8'h01;
      end
    end
  end

  // Power-good rises after soft-start in regulation and holds through any move.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || !en_s) begin
      outputs_in_regulation_flag_r <= 1'h0;
    end else if (state_r == ST_RUN && reg_s) begin
      outputs_in_regulation_flag_r <= 1'h1;
    end
  end

  // Any plane moving down forces continuous conduction.
  always_comb begin
    o_continuous_conduction_mode = 1'h0;
    for (int p = 0; p < NPLANE; p++) begin
      if (state_r == ST_RUN && tgt_r[p] > ref_r[p]) begin
        o_continuous_conduction_mode = 1'h1;
      end
    end
  end

  assign o_drivers_enable = (state_r != ST_OFF);
  assign o_outputs_in_regulation_flag = outputs_in_regulation_flag_r;
  assign o_power_saving_request_low = psi_r;
  assign o_plane_ref = ref_r;

  //////////////////////////////////////////////////////////////////////////////
  // Link clock domain: receiver for the send-byte transaction.

  logic [1:0] lrst_q, lpok_q;
  logic [2:0] lc_q, ld_q;
  logic scl_rise, scl_fall, start_c, stop_c;
  link_state_t lst_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic [2:0] pl_r;
  logic oe_r;

  // Reset and power-ok arrive as levels through two flops.
  always_ff @(posedge i_link_clk) begin
    lrst_q <= {lrst_q[0], i_rst_n};
    lpok_q <= {lpok_q[0], i_cpu_power_ok_input && !mode_s};
    lc_q <= {lc_q[1:0], i_vid_serial_clock_line};
    ld_q <= {ld_q[1:0], i_vid_serial_data_line};
  end

  assign scl_rise = lc_q[1] && !lc_q[2];
  assign scl_fall = !lc_q[1] && lc_q[2];
  assign start_c = lc_q[1] && lc_q[2] && !ld_q[1] && ld_q[2];
  assign stop_c = lc_q[1] && lc_q[2] && ld_q[1] && !ld_q[2];

  // Byte receive, acknowledge and stop; lines are ignored while power-ok is low.
  always_ff @(posedge i_link_clk) begin
    if (!lrst_q[1] || !lpok_q[1]) begin
      lst_r <= L_IDLE;
      oe_r <= 1'h0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      pl_r <= 3'h0;
      // The toggle keeps its level across power-ok loss, so no false command crosses.
      if (!lrst_q[1]) begin
        ltgl_r <= 1'h0;
        lcmd_r <= '0;
      end
    end else if (start_c) begin
      lst_r <= L_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'h0;
    end else if (stop_c) begin
      if (lst_r == L_STOP) begin
        ltgl_r <= !ltgl_r;
      end
      lst_r <= L_IDLE;
      oe_r <= 1'h0;
    end else begin
      case (lst_r)
        L_ADDR, L_DATA: begin
          if (scl_rise && cnt_r < BYTE_BITS) begin
            sh_r <= {sh_r[6:0], ld_q[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_r <= 4'h0;
            if (lst_r == L_DATA) begin
              lcmd_r <= '{planes: pl_r, power_saving_request_low: sh_r[DAT_PSI], vid: sh_r[6:0]};
              oe_r <= 1'h1;
              lst_r <= L_DACK;
            end else if (sh_r[ADR_TAG_HI:ADR_TAG_LO] == ADDR_TAG && sh_r[ADR_RW] == RW_WRITE) begin
              pl_r <= sh_r[ADR_PL_HI:ADR_PL_LO];
              oe_r <= 1'h1;
              lst_r <= L_AACK;
            end else begin
              lst_r <= L_IDLE;
            end
          end
        end
        L_AACK: begin
          if (scl_fall) begin
            oe_r <= 1'h0;
            lst_r <= L_DATA;
          end
        end
        L_DACK: begin
          if (scl_fall) begin
            oe_r <= 1'h0;
            lst_r <= L_STOP;
          end
        end
        default: oe_r <= 1'h0;
      endcase
    end
  end

  // The data line is open-drain: only ever pulled low.
  assign o_vid_serial_data_line_out = 1'h0;
  assign o_vid_serial_data_line_oe = oe_r;

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [7:0] gap_r;

  // Cycles since the first-core reference last moved, saturating.
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || ref_r[1] != $past(ref_r[1])) begin
      gap_r <= 8'h00;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  a_strap_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_OFF && en_s && !en_d |=> hold_r == strap_code($past(mode_s), $past(clk_q[1]), $past(dat_q[1])))
    else $error("start-up code not captured on enable");
  a_enable_loss: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !en_s |=> !o_outputs_in_regulation_flag && !o_drivers_enable && hold_r == VID_RST)
    else $error("enable loss did not shut down");
  a_outputs_in_regulation_flag_rise: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_outputs_in_regulation_flag) |-> $past(state_r == ST_RUN && reg_s))
    else $error("power-good rose before soft-start end");
  a_outputs_in_regulation_flag_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_outputs_in_regulation_flag && en_s |=> o_outputs_in_regulation_flag)
    else $error("power-good dropped with enable high");
  a_pok_return: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_RUN && en_s && !link_ok |=> tgt_r == {NPLANE{hold_r}})
    else $error("targets not returned to held code");
  a_step_one: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r != ST_OFF && $changed(ref_r[1]) |-> ref_r[1] - $past(ref_r[1]) == 7'h01
      || $past(ref_r[1]) - ref_r[1] == 7'h01 || $past(state_r) == ST_OFF)
    else $error("reference moved more than one code");
  a_slew_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_RUN && $past(state_r) == ST_RUN && $changed(ref_r[1]) |-> gap_r >= 8'(MAX_RATE_CYC - 1))
    else $error("reference slew too fast");
  a_ccm_down: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_RUN && tgt_r[0] > ref_r[0] |-> o_continuous_conduction_mode)
    else $error("continuous conduction not forced on down move");
  a_ack_addr: assert property (@(posedge i_link_clk) disable iff (!lrst_q[1])
    lst_r == L_AACK || lst_r == L_DACK |-> o_vid_serial_data_line_oe)
    else $error("acknowledge not driven");
  a_stop_first: assert property (@(posedge i_link_clk) disable iff (!lrst_q[1] || !lpok_q[1])
    $changed(ltgl_r) |-> $past(stop_c) && $past(lst_r) == L_STOP)
    else $error("command passed on without stop");
  // Command application, power-saving flag, idle targets, quiet link and soft-start pacing.
  a_cmd_apply: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cmd_go && en_s && cmd_r.planes[1] |=> tgt_r[1] == $past(cmd_r.vid))
    else $error("commanded code not applied to plane");
  a_psi_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    cmd_go && en_s |=> o_power_saving_request_low == $past(cmd_r.power_saving_request_low))
    else $error("power-saving flag not taken from command");
  a_idle_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_RUN && en_s && link_ok && !cmd_go |=> $stable(tgt_r))
    else $error("plane target moved without a command");
  a_link_quiet: assert property (@(posedge i_link_clk) disable iff (!lrst_q[1])
    !lpok_q[1] |=> !o_vid_serial_data_line_oe && lst_r == L_IDLE)
    else $error("link active while power-ok low");
  a_soft_rate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_r == ST_SOFT && $past(state_r) == ST_SOFT && $changed(ref_r[1]) && $past(ref_r[1]) != VID_FLOOR
      |-> gap_r == 8'(SS_CYCLES - 1))
    else $error("soft-start step spacing wrong");

  c_cmd_taken: cover property (@(posedge i_mclk) disable iff (!i_rst_n) cmd_go);
  c_outputs_in_regulation_flag_up: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $rose(o_outputs_in_regulation_flag));
  c_pok_drop: cover property (@(posedge i_mclk) disable iff (!i_rst_n) state_r == ST_RUN && $fell(pok_s));
  c_link_stop: cover property (@(posedge i_link_clk) disable iff (!lrst_q[1]) $changed(ltgl_r));
  c_soft_end: cover property (@(posedge i_mclk) disable iff (!i_rst_n) state_r == ST_SOFT ##1 state_r == ST_RUN);

endmodule : svid_seq

// >>> tb/svid_cpu_model.sv
// Processor-side model that drives the serial VID clock and data lines.
`timescale 1ns/10ps
module svid_cpu_model #(
  parameter int HALF_NS = 100
) (
  input wire logic i_dev_oe,
  output logic o_clk_line,
  output logic o_data_line
);
  logic drive_low;

  // The data wire has a pull-up: it is low only while either side pulls it down.
  assign o_data_line = !(drive_low || i_dev_oe);

  // Both lines idle high, and the clock line stands still outside frames.
  initial begin
    o_clk_line = 1'b1;
    drive_low = 1'b0;
  end

  ////////////////////////////////////////
  // Static strap levels, used before enable.
  task automatic set_straps(input logic c, input logic d);
    o_clk_line <= c;
    drive_low <= !d;
  endtask : set_straps

  // The data changes well after the clock fall, so it never moves while the clock is high.
  task automatic put_bit(input logic b, output logic seen);
    #(HALF_NS / 2);
    drive_low = !b;
    #(HALF_NS / 2);
    o_clk_line = 1'b1;
    #(HALF_NS);
    seen = o_data_line;
    o_clk_line = 1'b0;
  endtask : put_bit

  // Send-byte frame: start, address, ack, data, ack, stop; ack[1] is the address ack.
  task automatic send_cmd(input logic [7:0] adr, input logic [7:0] dat, output logic [1:0] ack);
    logic s;
    logic [15:0] bits;
    bits = {adr, dat};
    o_clk_line = 1'b1;
    drive_low = 1'b0;
    #(HALF_NS);
    drive_low = 1'b1;
    #(HALF_NS);
    o_clk_line = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      put_bit(bits[i], s);
      if (i % 8 == 0) begin
        put_bit(1'b1, s);
        ack[i / 8] = !s;
      end
    end
    #(HALF_NS / 2);
    drive_low = 1'b1;
    #(HALF_NS / 2);
    o_clk_line = 1'b1;
    #(HALF_NS / 2);
    drive_low = 1'b0;
    #(HALF_NS);
  endtask : send_cmd
endmodule : svid_cpu_model

// >>> tb/svid_seq_tb.sv
// Self-checking bench for the serial VID reference sequencer.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module svid_seq_tb import svid_seq_pkg::*;;
  localparam int SS = 4;
  localparam int SL = 25;
  logic i_mclk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_enable = 1'b0;
  logic fixed_mode = 1'b0;
  logic power_ok = 1'b0;
  logic in_reg = 1'b0;
  logic clk_line, data_line, oe, sda_out, drv_en, outputs_in_regulation_flag, continuous_conduction_mode, power_saving_request_low;
  vid_t [NPLANE-1:0] refs;
  vid_t last_q [NPLANE];
  int gap [NPLANE];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  svid_seq #(.SS_CYCLES(SS), .SLEW_CYCLES(SL)) u_svid_seq (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_link_clk(i_link_clk), .i_enable(i_enable), .i_fixed_strap_voltage_mode(fixed_mode),
    .i_cpu_power_ok_input(power_ok), .i_in_regulation(in_reg), .i_vid_serial_clock_line(clk_line),
    .i_vid_serial_data_line(data_line), .o_vid_serial_data_line_out(sda_out), .o_vid_serial_data_line_oe(oe),
    .o_drivers_enable(drv_en), .o_outputs_in_regulation_flag(outputs_in_regulation_flag), .o_continuous_conduction_mode(continuous_conduction_mode),
    .o_power_saving_request_low(power_saving_request_low), .o_plane_ref(refs));
  svid_cpu_model u_svid_cpu_model (.i_dev_oe(oe), .o_clk_line(clk_line), .o_data_line(data_line));

  // Main clock, and a link clock with an unrelated phase.
  initial forever #25 i_mclk = !i_mclk;
  initial begin
    #1.7;
    forever #3 i_link_clk = !i_link_clk;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      $display("timeout reached");
      test_done();
    end
  end

  // In run, each reference moves one code at a time, no faster than the rate limit.
  always @(negedge i_mclk) begin
    for (int p = 0; p < NPLANE; p++) begin
      if (refs[p] !== last_q[p]) begin
        if (outputs_in_regulation_flag === 1'b1 && last_q[p] < refs[p]) `CHK("step up", 7'h01, refs[p] - last_q[p])
        if (outputs_in_regulation_flag === 1'b1 && last_q[p] > refs[p]) `CHK("step down", 7'h01, last_q[p] - refs[p])
        if (outputs_in_regulation_flag === 1'b1) `CHK("step gap", 1'b1, gap[p] >= MAX_RATE_CYC)
        gap[p] = 0;
      end
      gap[p]++;
      last_q[p] = refs[p];
    end
  end

  ////////////////////////////////////////
  // Waits for a plane to reach a code, with a bound, and reports the cycles taken.
  task automatic wait_ref(input int p, input vid_t code, output int n);
    n = 0;
    while (refs[p] !== code && n < 4000) begin
      @(negedge i_mclk);
      n++;
    end
    `CHK("plane ref", code, refs[p])
  endtask : wait_ref

  task automatic send(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
    logic [1:0] ack;
    u_svid_cpu_model.send_cmd(a, d, ack);
    `CHK("acks", exp, ack)
  endtask : send

  // Every strap pair in both modes; the serial pair 00 comes last and stays up.
  task automatic t_startup;
    int n;
    vid_t code;
    for (int m = 1; m >= 0; m--) begin
      for (int k = 3; k >= 0; k--) begin
        code = vid_t'(m ? 12 + 16 * k : 36 + 8 * k); // (1.55 V - level) / 12.5 mV
        @(posedge i_mclk);
        fixed_mode <= m[0];
        u_svid_cpu_model.set_straps(k[1], k[0]);
        repeat (4) @(posedge i_mclk);
        i_enable <= 1'b1;
        repeat (5) @(posedge i_mclk);
        u_svid_cpu_model.set_straps(!k[1], !k[0]);
        @(negedge i_mclk);
        `CHK("drivers on", 1'b1, drv_en)
        `CHK("outputs_in_regulation_flag early", 1'b0, outputs_in_regulation_flag)
        wait_ref(0, code, n);
        `CHK("soft-start time", 1'b1, n >= (7'h7b - code - 1) * SS)
        for (int p = 1; p < NPLANE; p++) wait_ref(p, code, n);
        repeat (3) @(negedge i_mclk);
        `CHK("outputs_in_regulation_flag no reg", 1'b0, outputs_in_regulation_flag)
        @(posedge i_mclk);
        in_reg <= 1'b1;
        repeat (6) @(negedge i_mclk);
        `CHK("outputs_in_regulation_flag", 1'b1, outputs_in_regulation_flag)
        if (m != 0 || k != 0) begin
          @(posedge i_mclk);
          i_enable <= 1'b0;
          in_reg <= 1'b0;
          repeat (5) @(negedge i_mclk);
          `CHK("drivers off", 1'b0, drv_en)
          `CHK("outputs_in_regulation_flag off", 1'b0, outputs_in_regulation_flag)
        end
      end
    end
    $display("t_startup done");
  endtask : t_startup

  // Up, down and off moves, then refused addresses.
  task automatic t_command;
    int n;
    @(posedge i_mclk);
    power_ok <= 1'b1;
    repeat (10) @(posedge i_mclk);
    send(8'hce, 8'h14, 2'b11);
    `CHK("data drive level", 1'b0, sda_out)
    wait_ref(2, 7'h14, n);
    `CHK("up time", 1'b1, n >= 15 * SL)
    `CHK("psi low", 1'b0, power_saving_request_low)
    send(8'hcc, 8'hb0, 2'b11);
    repeat (10) @(negedge i_mclk);
    `CHK("ccm down", 1'b1, continuous_conduction_mode)
    wait_ref(1, 7'h30, n);
    `CHK("ccm after", 1'b0, continuous_conduction_mode)
    `CHK("nb kept", 7'h14, refs[0])
    `CHK("psi high", 1'b1, power_saving_request_low)
    send(8'hc8, 8'hfc, 2'b11);
    wait_ref(2, 7'h7c, n);
    `CHK("outputs_in_regulation_flag kept", 1'b1, outputs_in_regulation_flag)
    send(8'hae, 8'h40, 2'b00);
    send(8'hcf, 8'h40, 2'b00);
    repeat (60) @(negedge i_mclk);
    `CHK("nb unchanged", 7'h14, refs[0])
    $display("t_command done");
  endtask : t_command

  // Power-ok low returns all planes to the held code and ignores the link.
  task automatic t_pok_drop;
    int n;
    @(posedge i_mclk);
    power_ok <= 1'b0;
    for (int p = 0; p < NPLANE; p++) wait_ref(p, 7'h24, n);
    `CHK("psi reset", 1'b1, power_saving_request_low)
    send(8'hce, 8'h14, 2'b00);
    @(posedge i_mclk);
    power_ok <= 1'b1;
    repeat (60) @(negedge i_mclk);
    `CHK("held", 7'h24, refs[0])
    send(8'hc2, 8'h20, 2'b11);
    wait_ref(0, 7'h20, n);
    `CHK("core held", 7'h24, refs[1])
    $display("t_pok_drop done");
  endtask : t_pok_drop

  // Supply reset mid-run, then a fresh start from new straps.
  task automatic t_reset;
    int n;
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    i_enable <= 1'b0;
    power_ok <= 1'b0;
    in_reg <= 1'b0;
    repeat (6) @(negedge i_mclk);
    `CHK("outputs_in_regulation_flag rst", 1'b0, outputs_in_regulation_flag)
    `CHK("drivers rst", 1'b0, drv_en)
    `CHK("refs rst", {NPLANE{7'h7b}}, refs)
    u_svid_cpu_model.set_straps(1'b0, 1'b1);
    @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    i_enable <= 1'b1;
    wait_ref(0, 7'h2c, n);
    $display("t_reset done");
  endtask : t_reset

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Reset for 16 cycles, then the scenarios in order.
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_startup();
    t_command();
    t_pok_drop();
    t_reset();
    test_done();
  end
endmodule : svid_seq_tb
